// >>> core/ddr_pins_map.svh
// named offsets, field positions, command codes and reset values of the pin logic
// assumes inclusion by bare name from the package and the modules
`ifndef DDR_PINS_MAP_SVH
`define DDR_PINS_MAP_SVH

// address and bank widths and mode register count of the documented part
`define ADDR_W 14
`define BA_W 2
`define MR_CNT 4

// address bit that carries auto precharge or precharge-all
`define AP_BIT 10

// command codes as {cs_n, ras_n, cas_n, we_n}
`define CMD_MRS 4'h0
`define CMD_REF 4'h1
`define CMD_PRE 4'h2
`define CMD_ACT 4'h3
`define CMD_WR 4'h4
`define CMD_RD 4'h5

// extended mode register index and its fields
`define EMR1_IDX 2'h1
`define EMR_RTT0_BIT 2
`define EMR_RTT1_BIT 6
`define EMR_RDQS_BIT 11

// reset value and lane width
`define MR_RST 14'h0000
`define LANE_BITS 8

`endif

// >>> core/ddr_pins_pkg.sv
// types shared by the pin logic and its command crossing
// assumes the map header is on the include path
`include "ddr_pins_map.svh"

package ddr_pins_pkg;

   typedef enum logic [1:0] {
      PWR_ON,
      PWR_PRE_PD,
      PWR_ACT_PD,
      PWR_SELF_REF
   } pwr_t;

   typedef enum logic [2:0] {
      KIND_ACTIVATE,
      KIND_READ,
      KIND_WRITE,
      KIND_PRECHARGE,
      KIND_REFRESH,
      KIND_MODE_SET
   } cmd_kind_t;

   typedef struct packed {
      cmd_kind_t kind;
      logic [`BA_W-1:0] bank;
      logic [`ADDR_W-1:0] addr;
      logic auto_pre;
      logic all_banks;
   } cmd_t;

   typedef struct packed {
      logic clk;
      logic odt;
      logic cke;
      logic cmd;
      logic data;
   } buf_en_t;

endpackage : ddr_pins_pkg

// >>> core/cmd_xfer.sv
// carries one command word from the link clock to the core clock
// assumes the core clock samples at least three times per link period,
// so a held word with a toggle is enough and no ack is returned
`timescale 1ns/1ps

module cmd_xfer (
   // source side, link clock
   input wire logic src_clk_i,
   input wire logic src_rst_i,
   input wire logic src_go_i,
   input wire ddr_pins_pkg::cmd_t src_data_i,
   // destination side, core clock
   input wire logic dst_clk_i,
   input wire logic dst_rst_i,
   output logic dst_valid_o,
   output ddr_pins_pkg::cmd_t dst_data_o
);

   logic tgl_q, tgl_d;
   ddr_pins_pkg::cmd_t hold_q, hold_d;
   logic s1_q, s2_q, s3_q;
   logic valid_q, valid_d;
   ddr_pins_pkg::cmd_t out_q, out_d;

   always_comb begin
      tgl_d = tgl_q;
      hold_d = hold_q;
      if (src_go_i) begin
         tgl_d = ~tgl_q;
         hold_d = src_data_i;
      end
   end

   always_ff @(posedge src_clk_i) begin
      if (src_rst_i) begin
         tgl_q <= 1'b0;
         hold_q <= '0;
      end else begin
         tgl_q <= tgl_d;
         hold_q <= hold_d;
      end
   end

   // word changes with the toggle and stays stable for a full link period, past the two-stage sync
   always_comb begin
      valid_d = s2_q ^ s3_q;
      out_d = out_q;
      if (s2_q ^ s3_q) begin
         out_d = hold_q;
      end
   end

   always_ff @(posedge dst_clk_i) begin
      if (dst_rst_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         valid_q <= 1'b0;
         out_q <= '0;
      end else begin
         s1_q <= tgl_q;
         s2_q <= s1_q;
         s3_q <= s2_q;
         valid_q <= valid_d;
         out_q <= out_d;
      end
   end

   assign dst_valid_o = valid_q;
   assign dst_data_o = out_q;

endmodule : cmd_xfer

// >>> core/ddr_pin_ctrl.sv
// control-pin logic of a DDR2 memory device: power states, buffer gating,
// command decode, bank and mode register tracking, termination and write masks
// assumes ck_i keeps running while srst_i is held, and that write beats arrive
// already captured on both strobe edges and presented once per ck_i cycle
//
// How it works
// - cke high keeps clocks, input buffers and drivers on; cke low turns off the drivers, the internal clock and the command and data buffers
// - cke low with a refresh code gives self refresh; otherwise all banks idle gives precharge power-down, else active
// - cke is sampled on ck for entry and exit; self refresh exit is seen without ck
// - in power-down only clock, termination control and cke buffers stay on
// - in self refresh only the cke buffer stays on
// - any command with chip select registered high is ignored
// - command is decoded from chip select, ras, cas and we together
// - registered odt turns on termination for data, strobes and masks of every lane
// - odt is ignored while the extended mode register disables termination
// - a write beat with its mask sampled high is discarded
// - on the eight-bit part the shared pin is mask or read strobe per extended mode
// - activate, read, write and precharge act on the sampled bank address
// - bank address picks the mode register written by a mode set
// - activate takes the row; read and write take column and auto precharge
// - precharge with address bit ten low closes one bank, high closes all
// - mode set loads the address inputs as the selected register's opcode
// - all address and control pins are sampled on the rising edge of ck
`timescale 1ns/1ps
`include "ddr_pins_map.svh"

module ddr_pin_ctrl #(
   parameter int LANES = 2,
   parameter int BANKS = 4,
   parameter bit NARROW8 = 1'b0
) (
   // core clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // link clock from the controller
   input wire logic ck_i,
   // command and control pins
   input wire logic cke_i,
   input wire logic cs_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic odt_i,
   input wire logic [`BA_W-1:0] ba_i,
   input wire logic [`ADDR_W-1:0] addr_i,
   // captured write beats, link clock
   input wire logic beat_valid_i,
   input wire logic [LANES*`LANE_BITS-1:0] beat_data_i,
   input wire logic [LANES-1:0] beat_dm_i,
   // pad and array controls, link clock
   output ddr_pins_pkg::buf_en_t buf_en_o,
   output logic clk_run_o,
   output logic drv_en_o,
   output logic [LANES-1:0] term_en_o,
   output logic rdqs_mode_o,
   output logic [LANES-1:0] wr_lane_en_o,
   output logic [LANES*`LANE_BITS-1:0] wr_data_o,
   output logic [BANKS-1:0] bank_open_o,
   output logic [`ADDR_W-1:0] emr1_o,
   // decoded commands and power status, core clock
   output logic cmd_valid_o,
   output ddr_pins_pkg::cmd_t cmd_o,
   output logic power_down_o,
   output logic self_refresh_o
);

   // reset into the link domain
   logic rst_ck1_q, rst_ck2_q;

   always_ff @(posedge ck_i) begin
      rst_ck1_q <= srst_i;
      rst_ck2_q <= rst_ck1_q;
   end

   // pin capture on the rising ck edge
   logic cke_q, cke_prev_q, cs_n_q, ras_n_q, cas_n_q, we_n_q, odt_q;
   logic [`BA_W-1:0] ba_q;
   logic [`ADDR_W-1:0] addr_q;

   always_ff @(posedge ck_i) begin
      if (rst_ck2_q) begin
         cke_q <= 1'b0;
         cke_prev_q <= 1'b0;
         cs_n_q <= 1'b1;
         ras_n_q <= 1'b1;
         cas_n_q <= 1'b1;
         we_n_q <= 1'b1;
         odt_q <= 1'b0;
         ba_q <= '0;
         addr_q <= '0;
      end else begin
         cke_q <= cke_i;
         cke_prev_q <= cke_q;
         cs_n_q <= cs_n_i;
         ras_n_q <= ras_n_i;
         cas_n_q <= cas_n_i;
         we_n_q <= we_n_i;
         odt_q <= odt_i;
         ba_q <= ba_i;
         addr_q <= addr_i;
      end
   end

   // self refresh exit handed over from the core domain
   logic exit_s1_q, exit_s2_q, exit_s3_q;
   logic exit_tgl_q, exit_tgl_d;
   logic sr_exit_seen;

   always_ff @(posedge ck_i) begin
      if (rst_ck2_q) begin
         exit_s1_q <= 1'b0;
         exit_s2_q <= 1'b0;
         exit_s3_q <= 1'b0;
      end else begin
         exit_s1_q <= exit_tgl_q;
         exit_s2_q <= exit_s1_q;
         exit_s3_q <= exit_s2_q;
      end
   end

   assign sr_exit_seen = exit_s2_q ^ exit_s3_q;

   // power state, bank tracking and mode registers, link clock
   ddr_pins_pkg::pwr_t pwr_q, pwr_d;
   logic [BANKS-1:0] open_q, open_d;
   logic [`ADDR_W-1:0] mr_q [`MR_CNT];
   logic [`ADDR_W-1:0] mr_d [`MR_CNT];
   logic go;
   ddr_pins_pkg::cmd_t cmd_w;
   logic [3:0] code;
   logic cmd_ok;

   assign code = {cs_n_q, ras_n_q, cas_n_q, we_n_q};

   always_comb begin
      pwr_d = pwr_q;
      open_d = open_q;
      mr_d = mr_q;
      go = 1'b0;
      cmd_w = '0;
      cmd_w.bank = ba_q;
      cmd_w.addr = addr_q;
      // commands count only with the clock enabled on the last two ck rises and chip selected
      cmd_ok = (pwr_q == ddr_pins_pkg::PWR_ON) && cke_q && cke_prev_q && !cs_n_q;
      case (pwr_q)
         ddr_pins_pkg::PWR_ON: begin
            if (cke_prev_q && !cke_q) begin
               if (code == `CMD_REF) begin
                  pwr_d = ddr_pins_pkg::PWR_SELF_REF;
               end else if (|open_q) begin
                  pwr_d = ddr_pins_pkg::PWR_ACT_PD;
               end else begin
                  pwr_d = ddr_pins_pkg::PWR_PRE_PD;
               end
            end
         end
         ddr_pins_pkg::PWR_PRE_PD, ddr_pins_pkg::PWR_ACT_PD: begin
            if (cke_q) begin
               pwr_d = ddr_pins_pkg::PWR_ON;
            end
         end
         ddr_pins_pkg::PWR_SELF_REF: begin
            if (sr_exit_seen) begin
               pwr_d = ddr_pins_pkg::PWR_ON;
            end
         end
         default: begin
            pwr_d = ddr_pins_pkg::PWR_ON;
         end
      endcase
      if (cmd_ok) begin
         case (code)
            `CMD_ACT: begin
               open_d[ba_q] = 1'b1;
               cmd_w.kind = ddr_pins_pkg::KIND_ACTIVATE;
               go = 1'b1;
            end
            `CMD_RD, `CMD_WR: begin
               cmd_w.kind = we_n_q ? ddr_pins_pkg::KIND_READ : ddr_pins_pkg::KIND_WRITE;
               cmd_w.auto_pre = addr_q[`AP_BIT];
               // bank closes when its auto-precharge burst is handed on
               if (addr_q[`AP_BIT]) begin
                  open_d[ba_q] = 1'b0;
               end
               go = 1'b1;
            end
            `CMD_PRE: begin
               cmd_w.kind = ddr_pins_pkg::KIND_PRECHARGE;
               cmd_w.all_banks = addr_q[`AP_BIT];
               if (addr_q[`AP_BIT]) begin
                  open_d = '0;
               end else begin
                  open_d[ba_q] = 1'b0;
               end
               go = 1'b1;
            end
            `CMD_REF: begin
               cmd_w.kind = ddr_pins_pkg::KIND_REFRESH;
               go = 1'b1;
            end
            `CMD_MRS: begin
               cmd_w.kind = ddr_pins_pkg::KIND_MODE_SET;
               mr_d[ba_q] = addr_q;
               go = 1'b1;
            end
            default: begin
               go = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge ck_i) begin
      if (rst_ck2_q) begin
         pwr_q <= ddr_pins_pkg::PWR_ON;
         open_q <= '0;
         for (int i = 0; i < `MR_CNT; i++) begin
            mr_q[i] <= `MR_RST;
         end
      end else begin
         pwr_q <= pwr_d;
         open_q <= open_d;
         mr_q <= mr_d;
      end
   end

   // pad gating and termination, link clock
   logic rtt_on, rdqs_mode, term_any;
   ddr_pins_pkg::buf_en_t buf_d, buf_q;
   logic run_d, run_q;
   logic [LANES-1:0] term_d, term_q;

   assign rtt_on = mr_q[`EMR1_IDX][`EMR_RTT0_BIT] | mr_q[`EMR1_IDX][`EMR_RTT1_BIT];
   assign rdqs_mode = NARROW8 && mr_q[`EMR1_IDX][`EMR_RDQS_BIT];
   // termination control input is dead in self refresh, so odt cannot act there
   assign term_any = odt_q && rtt_on && (pwr_q != ddr_pins_pkg::PWR_SELF_REF);

   always_comb begin
      buf_d.cke = 1'b1;
      run_d = 1'b0;
      buf_d.clk = 1'b0;
      buf_d.odt = 1'b0;
      buf_d.cmd = 1'b0;
      buf_d.data = 1'b0;
      case (pwr_d)
         ddr_pins_pkg::PWR_ON: begin
            run_d = 1'b1;
            buf_d.clk = 1'b1;
            buf_d.odt = 1'b1;
            buf_d.cmd = 1'b1;
            buf_d.data = 1'b1;
         end
         ddr_pins_pkg::PWR_PRE_PD, ddr_pins_pkg::PWR_ACT_PD: begin
            buf_d.clk = 1'b1;
            buf_d.odt = 1'b1;
         end
         default: begin
            run_d = 1'b0;
         end
      endcase
   end

   // every lane's data, strobe and mask share one enable
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         assign term_d[g] = term_any;
      end
   endgenerate

   always_ff @(posedge ck_i) begin
      if (rst_ck2_q) begin
         buf_q <= '0;
         run_q <= 1'b0;
         term_q <= '0;
      end else begin
         buf_q <= buf_d;
         run_q <= run_d;
         term_q <= term_d;
      end
   end

   // write beat masking, link clock
   logic [LANES-1:0] wen_d, wen_q;
   logic [LANES*`LANE_BITS-1:0] wdat_d, wdat_q;

   // burst beats rely on cke staying high, so no power check here
   generate
      for (g = 0; g < LANES; g++) begin : g_mask
         // the shared pin is a read strobe in rdqs mode, so its level masks nothing
         assign wen_d[g] = beat_valid_i && (rdqs_mode || !beat_dm_i[g]);
      end
   endgenerate

   assign wdat_d = beat_valid_i ? beat_data_i : wdat_q;

   always_ff @(posedge ck_i) begin
      if (rst_ck2_q) begin
         wen_q <= '0;
         wdat_q <= '0;
      end else begin
         wen_q <= wen_d;
         wdat_q <= wdat_d;
      end
   end

   // status levels for the core domain
   logic pd_flag_q, sr_flag_q;

   always_ff @(posedge ck_i) begin
      if (rst_ck2_q) begin
         pd_flag_q <= 1'b0;
         sr_flag_q <= 1'b0;
      end else begin
         pd_flag_q <= (pwr_d == ddr_pins_pkg::PWR_PRE_PD) || (pwr_d == ddr_pins_pkg::PWR_ACT_PD);
         sr_flag_q <= (pwr_d == ddr_pins_pkg::PWR_SELF_REF);
      end
   end

   // core domain: cke seen without ck, self refresh exit
   logic cke_s1_q, cke_s2_q, sr_s1_q, sr_s2_q, pd_s1_q, pd_s2_q;
   logic sent_q, sent_d;

   always_comb begin
      exit_tgl_d = exit_tgl_q;
      sent_d = sent_q;
      if (!sr_s2_q) begin
         sent_d = 1'b0;
      end else if (cke_s2_q && !sent_q) begin
         exit_tgl_d = ~exit_tgl_q;
         sent_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cke_s1_q <= 1'b0;
         cke_s2_q <= 1'b0;
         sr_s1_q <= 1'b0;
         sr_s2_q <= 1'b0;
         pd_s1_q <= 1'b0;
         pd_s2_q <= 1'b0;
         exit_tgl_q <= 1'b0;
         sent_q <= 1'b0;
      end else begin
         cke_s1_q <= cke_i;
         cke_s2_q <= cke_s1_q;
         sr_s1_q <= sr_flag_q;
         sr_s2_q <= sr_s1_q;
         pd_s1_q <= pd_flag_q;
         pd_s2_q <= pd_s1_q;
         exit_tgl_q <= exit_tgl_d;
         sent_q <= sent_d;
      end
   end

   cmd_xfer u_cmd_xfer (
      .src_clk_i(ck_i),
      .src_rst_i(rst_ck2_q),
      .src_go_i(go),
      .src_data_i(cmd_w),
      .dst_clk_i(clk_i),
      .dst_rst_i(srst_i),
      .dst_valid_o(cmd_valid_o),
      .dst_data_o(cmd_o)
   );

   assign buf_en_o = buf_q;
   assign clk_run_o = run_q;
   assign drv_en_o = run_q;
   assign term_en_o = term_q;
   assign rdqs_mode_o = rdqs_mode;
   assign wr_lane_en_o = wen_q;
   assign wr_data_o = wdat_q;
   assign bank_open_o = open_q;
   assign emr1_o = mr_q[`EMR1_IDX];
   assign power_down_o = pd_s2_q;
   assign self_refresh_o = sr_s2_q;

endmodule : ddr_pin_ctrl

// >>> test/ddr_pin_ctrl_monitor.sv
// checker on the pin logic ports: buffer gating, command effects, termination, masks
// assumes srst_i resets both domains and ck_i rises where the pins are sampled
`timescale 1ns/1ps
`include "ddr_pins_map.svh"

module ddr_pin_ctrl_monitor #(
   parameter int LANES = 2,
   parameter int BANKS = 4
) (
   // clocks and reset
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ck_i,
   // pins
   input wire logic cke_i,
   input wire logic cs_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic odt_i,
   input wire logic [`BA_W-1:0] ba_i,
   input wire logic [`ADDR_W-1:0] addr_i,
   input wire logic beat_valid_i,
   input wire logic [LANES-1:0] beat_dm_i,
   // outputs
   input wire ddr_pins_pkg::buf_en_t buf_en_o,
   input wire logic clk_run_o,
   input wire logic drv_en_o,
   input wire logic [LANES-1:0] term_en_o,
   input wire logic [LANES-1:0] wr_lane_en_o,
   input wire logic rdqs_mode_o,
   input wire logic [BANKS-1:0] bank_open_o,
   input wire logic [`ADDR_W-1:0] emr1_o,
   input wire logic cmd_valid_o,
   input wire ddr_pins_pkg::cmd_t cmd_o
);
   logic [3:0] code;
   logic rtt_on;
   assign code = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
   assign rtt_on = emr1_o[`EMR_RTT0_BIT] | emr1_o[`EMR_RTT1_BIT];

   // a command only counts with cke steady high and the device fully on
   sequence live;
      cke_i && $past(cke_i) && $past(cke_i, 2) && buf_en_o.cmd;
   endsequence
   sequence act_cmd;
      live ##0 code == `CMD_ACT;
   endsequence
   sequence pre_all_cmd;
      live ##0 (code == `CMD_PRE && addr_i[`AP_BIT]);
   endsequence
   sequence emr_cmd;
      live ##0 (code == `CMD_MRS && ba_i == `EMR1_IDX);
   endsequence

   act_open_a: assert property (@(posedge ck_i) disable iff (srst_i)
      act_cmd |-> ##2 bank_open_o[$past(ba_i, 2)]) else $error("activate left bank closed");
   pre_all_a: assert property (@(posedge ck_i) disable iff (srst_i)
      pre_all_cmd |-> ##2 bank_open_o == '0) else $error("precharge all left a bank open");
   emr_load_a: assert property (@(posedge ck_i) disable iff (srst_i)
      emr_cmd |-> ##2 emr1_o == $past(addr_i, 2)) else $error("mode set opcode not loaded");
   deselect_a: assert property (@(posedge ck_i) disable iff (srst_i)
      cs_n_i |-> ##2 $stable(bank_open_o) && $stable(emr1_o)) else $error("deselect acted");
   term_cause_a: assert property (@(posedge ck_i) disable iff (srst_i)
      term_en_o != '0 |-> $past(odt_i, 2)) else $error("termination without odt");
   term_off_a: assert property (@(posedge ck_i) disable iff (srst_i)
      !rtt_on && !$past(rtt_on) |-> term_en_o == '0) else $error("odt not ignored");
   wr_mask_a: assert property (@(posedge ck_i) disable iff (srst_i)
      beat_valid_i && !rdqs_mode_o |-> ##1 wr_lane_en_o == ~$past(beat_dm_i))
      else $error("mask not applied");
   on_all_a: assert property (@(posedge clk_i) disable iff (srst_i)
      buf_en_o.cmd |-> buf_en_o == 5'h1F && clk_run_o && drv_en_o) else $error("partly on");
   pd_bufs_a: assert property (@(posedge clk_i) disable iff (srst_i)
      buf_en_o.clk && !buf_en_o.cmd |-> buf_en_o == 5'h1C && !clk_run_o && !drv_en_o)
      else $error("power-down buffers wrong");
   sr_bufs_a: assert property (@(posedge clk_i) disable iff (srst_i)
      !buf_en_o.clk |-> !buf_en_o.odt && !buf_en_o.cmd && !buf_en_o.data && !clk_run_o)
      else $error("self refresh buffers wrong");
   mrs_note_a: assert property (@(posedge clk_i) disable iff (srst_i)
      $changed(emr1_o) |-> ##[1:8] cmd_valid_o && cmd_o.kind == ddr_pins_pkg::KIND_MODE_SET)
      else $error("mode set not reported");
endmodule : ddr_pin_ctrl_monitor

bind ddr_pin_ctrl ddr_pin_ctrl_monitor #(.LANES(LANES), .BANKS(BANKS)) u_ddr_pin_ctrl_monitor (
   .clk_i(clk_i), .srst_i(srst_i), .ck_i(ck_i), .cke_i(cke_i), .cs_n_i(cs_n_i),
   .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i), .odt_i(odt_i), .ba_i(ba_i),
   .addr_i(addr_i), .beat_valid_i(beat_valid_i), .beat_dm_i(beat_dm_i),
   .buf_en_o(buf_en_o), .clk_run_o(clk_run_o), .drv_en_o(drv_en_o), .term_en_o(term_en_o),
   .wr_lane_en_o(wr_lane_en_o), .rdqs_mode_o(rdqs_mode_o), .bank_open_o(bank_open_o),
   .emr1_o(emr1_o), .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o)
);

// >>> test/ddr_ctrl_model.sv
// controller side: drives command, termination and write-beat pins
// assumes ck_i comes from the bench; pins change 2 ns after ck_i rises
`timescale 1ns/1ps
`include "ddr_pins_map.svh"

module ddr_ctrl_model (
   // link clock
   input wire logic ck_i,
   // pins toward the device
   output logic cke_o,
   output logic cs_n_o,
   output logic ras_n_o,
   output logic cas_n_o,
   output logic we_n_o,
   output logic odt_o,
   output logic [`BA_W-1:0] ba_o,
   output logic [`ADDR_W-1:0] addr_o,
   output logic beat_valid_o,
   output logic [2*`LANE_BITS-1:0] beat_data_o,
   output logic [1:0] beat_dm_o
);
   initial begin
      cke_o = 1'b0;
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
      odt_o = 1'b0;
      ba_o = 2'h0;
      addr_o = 14'h0000;
      beat_valid_o = 1'b0;
      beat_data_o = 16'h0000;
      beat_dm_o = 2'h0;
   end

   // held through one rise so the device samples a settled code
   task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} = c;
      ba_o = b;
      addr_o = a;
      @(posedge ck_i);
      #2;
   endtask : issue

   // deselected: address lines flip so a stale value cannot pass as fresh
   task automatic idle(input int n);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
      addr_o = ~addr_o;
      ba_o = ~ba_o;
      repeat (n) @(posedge ck_i);
      #2;
   endtask : idle

   // cke only moves between bursts, never inside one
   task automatic set_cke(input logic v);
      cke_o = v;
   endtask : set_cke

   task automatic set_odt(input logic v);
      odt_o = v;
   endtask : set_odt

   task automatic beat(input logic [15:0] d, input logic [1:0] m);
      beat_valid_o = 1'b1;
      beat_data_o = d;
      beat_dm_o = m;
      @(posedge ck_i);
      #2;
      beat_valid_o = 1'b0;
      beat_data_o = ~d;
      beat_dm_o = ~m;
   endtask : beat
endmodule : ddr_ctrl_model

// >>> test/ddr_pin_ctrl_bench.sv
// self-checking bench: controller model on the pins, core clock 40 MHz
// assumes the link clock may stop only while the device self-refreshes
`timescale 1ns/1ps
`include "ddr_pins_map.svh"

module ddr_pin_ctrl_bench;
   logic clk_i, ck_i, ck_run, srst_i;
   logic cke, cs_n, ras_n, cas_n, we_n, odt, beat_valid;
   logic [1:0] ba, beat_dm, term_en, wr_lane_en;
   logic [13:0] addr, emr1;
   logic [15:0] beat_data, wr_data;
   logic clk_run, drv_en, rdqs_mode, cmd_valid, pdn, sref;
   logic [3:0] bank_open;
   ddr_pins_pkg::buf_en_t buf_en;
   ddr_pins_pkg::cmd_t cmd_seen, last_cmd;
   logic rdqs_x8, wr_lane_x8;
   int num_errors = 0;
   int tests_run = 0;
   int cycles = 0;

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // unrelated phase; stands still while ck_run is low
   initial begin
      ck_i = 1'b0;
      #7;
      forever #62.5 if (ck_run) ck_i = ~ck_i;
   end

   ddr_pin_ctrl u_ddr_pin_ctrl (.clk_i(clk_i), .srst_i(srst_i), .ck_i(ck_i), .cke_i(cke),
      .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .odt_i(odt), .ba_i(ba),
      .addr_i(addr), .beat_valid_i(beat_valid), .beat_data_i(beat_data), .beat_dm_i(beat_dm),
      .buf_en_o(buf_en), .clk_run_o(clk_run), .drv_en_o(drv_en), .term_en_o(term_en),
      .rdqs_mode_o(rdqs_mode), .wr_lane_en_o(wr_lane_en), .wr_data_o(wr_data),
      .bank_open_o(bank_open), .emr1_o(emr1), .cmd_valid_o(cmd_valid), .cmd_o(cmd_seen),
      .power_down_o(pdn), .self_refresh_o(sref));
   // eight-bit part on the same pins: the shared pin follows the extended mode setting
   ddr_pin_ctrl #(.LANES(1), .NARROW8(1'b1)) u_ddr_pin_ctrl_x8 (.clk_i(clk_i), .srst_i(srst_i),
      .ck_i(ck_i), .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n),
      .odt_i(odt), .ba_i(ba), .addr_i(addr), .beat_valid_i(beat_valid),
      .beat_data_i(beat_data[7:0]), .beat_dm_i(beat_dm[0]), .buf_en_o(), .clk_run_o(),
      .drv_en_o(), .term_en_o(), .rdqs_mode_o(rdqs_x8), .wr_lane_en_o(wr_lane_x8),
      .wr_data_o(), .bank_open_o(), .emr1_o(), .cmd_valid_o(), .cmd_o(), .power_down_o(),
      .self_refresh_o());
   ddr_ctrl_model u_ddr_ctrl_model (.ck_i(ck_i), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n),
      .cas_n_o(cas_n), .we_n_o(we_n), .odt_o(odt), .ba_o(ba), .addr_o(addr),
      .beat_valid_o(beat_valid), .beat_data_o(beat_data), .beat_dm_o(beat_dm));

   task automatic results();
      if (num_errors == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a, int n);
      u_ddr_ctrl_model.issue(c, b, a);
      u_ddr_ctrl_model.idle(n);
   endtask : cmd

   // the pulse is one core cycle wide, so it is caught here
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cmd_valid === 1'b1) last_cmd <= cmd_seen;
      if (cycles == 6000) begin
         num_errors++;
         results();
      end
   end

   initial begin
      ck_run = 1'b1;
      srst_i = 1'b1;
      repeat (16) @(posedge clk_i);
      #2;
      srst_i = 1'b0;
      u_ddr_ctrl_model.idle(1);
      u_ddr_ctrl_model.set_cke(1'b1);
      u_ddr_ctrl_model.idle(4);
      check("on", {buf_en, clk_run, drv_en}, 7'h7F);
      cmd(`CMD_MRS, `EMR1_IDX, 14'h0804, 1);
      check("emr1", emr1, 14'h0804);
      check("rdqs x8", rdqs_x8, 1'b1);
      u_ddr_ctrl_model.beat(16'h00FF, 2'h3);
      check("x8 rdqs beat", {wr_lane_x8, wr_lane_en}, 3'h4);
      cmd(`CMD_MRS, 2'h0, 14'h0123, 1);
      check("emr1 kept", emr1, 14'h0804);
      check("rdqs", rdqs_mode, 1'b0);
      u_ddr_ctrl_model.set_odt(1'b1);
      u_ddr_ctrl_model.idle(2);
      check("term", term_en, 2'h3);
      cmd(`CMD_MRS, `EMR1_IDX, 14'h0000, 3);
      check("term off", term_en, 2'h0);
      check("rdqs x8 off", rdqs_x8, 1'b0);
      check("mrs", last_cmd.kind, ddr_pins_pkg::KIND_MODE_SET);
      u_ddr_ctrl_model.set_odt(1'b0);
      cmd(`CMD_ACT, 2'h1, 14'h1ABC, 3);
      check("act", {bank_open, last_cmd.bank, last_cmd.addr}, {4'h2, 2'h1, 14'h1ABC});
      cmd(`CMD_ACT | 4'h8, 2'h2, 14'h0000, 1);
      cmd(4'h7, 2'h2, 14'h0000, 3);
      check("ignored", {bank_open, last_cmd.addr}, {4'h2, 14'h1ABC});
      cmd(`CMD_WR, 2'h1, 14'h0400, 0);
      u_ddr_ctrl_model.beat(16'hA55A, 2'h1);
      check("beat", {wr_lane_en, wr_data}, {2'h2, 16'hA55A});
      check("beat x8", wr_lane_x8, 1'b0);
      u_ddr_ctrl_model.idle(2);
      check("wr ap", {last_cmd.kind, last_cmd.auto_pre, bank_open}, {3'h2, 1'b1, 4'h0});
      u_ddr_ctrl_model.issue(`CMD_ACT, 2'h0, 14'h0001);
      u_ddr_ctrl_model.issue(`CMD_ACT, 2'h2, 14'h0002);
      cmd(`CMD_RD, 2'h2, 14'h0010, 3);
      check("rd", {bank_open, last_cmd.kind, last_cmd.auto_pre}, {4'h5, 3'h1, 1'b0});
      cmd(`CMD_PRE, 2'h0, 14'h0000, 1);
      check("pre one", bank_open, 4'h4);
      cmd(`CMD_PRE, 2'h1, 14'h0400, 3);
      check("pre all", {bank_open, last_cmd.all_banks}, {4'h0, 1'b1});
      cmd(`CMD_ACT, 2'h3, 14'h0003, 1);
      u_ddr_ctrl_model.set_cke(1'b0);
      u_ddr_ctrl_model.idle(2);
      check("pd", {buf_en, clk_run}, 6'h38);
      u_ddr_ctrl_model.idle(1);
      check("pd flag", {pdn, sref}, 2'h2);
      u_ddr_ctrl_model.set_cke(1'b1);
      u_ddr_ctrl_model.idle(2);
      check("pd exit", buf_en, 5'h1F);
      cmd(`CMD_PRE, 2'h0, 14'h0400, 1);
      u_ddr_ctrl_model.set_cke(1'b0);
      cmd(`CMD_REF, 2'h0, 14'h0000, 2);
      check("sr", {buf_en, clk_run}, 6'h08);
      u_ddr_ctrl_model.idle(1);
      check("sr flag", {pdn, sref}, 2'h1);
      // exit is raised with the link clock stopped
      ck_run = 1'b0;
      repeat (8) @(posedge clk_i);
      #2;
      u_ddr_ctrl_model.set_cke(1'b1);
      repeat (8) @(posedge clk_i);
      ck_run = 1'b1;
      u_ddr_ctrl_model.idle(6);
      check("sr exit", {buf_en, pdn, sref}, 7'h7C);
      cmd(`CMD_ACT, 2'h0, 14'h0005, 1);
      check("after sr", bank_open, 4'h1);
      results();
   end
endmodule : ddr_pin_ctrl_bench
